// ===== hw/eamt_pkg.sv
package eamt_pkg;
  // Addressing modes
  typedef enum logic [4:0] {
    EAMT_M_DREG, EAMT_M_AREG, EAMT_M_IND, EAMT_M_POSTINC, EAMT_M_PREDEC,
    EAMT_M_D16, EAMT_M_ABSW, EAMT_M_ABSL, EAMT_M_IMMB, EAMT_M_IMMW,
    EAMT_M_IMML, EAMT_M_D8X, EAMT_M_FSUP, EAMT_M_FD16, EAMT_M_FD32,
    EAMT_M_FIND, EAMT_M_FX, EAMT_M_FINDX, EAMT_M_FBD16, EAMT_M_FBD32,
    EAMT_M_FBD16X, EAMT_M_FBD32X, EAMT_M_FBD16XS, EAMT_M_FBD32XS
  } eamt_mode_t;

  // Move forms in scan order
  typedef enum logic [3:0] {
    EAMT_F_RR, EAMT_F_FEA_R, EAMT_F_R_IND, EAMT_F_R_PI, EAMT_F_R_PD,
    EAMT_F_R_CEA, EAMT_F_FEA_IND, EAMT_F_FEA_PI, EAMT_F_FEA_PD,
    EAMT_F_IMM_CEA, EAMT_F_GEN
  } eamt_form_t;

  typedef struct packed {
    logic signed [7:0] head;
    logic signed [7:0] tail;
    logic [7:0] cycles;
    logic [3:0] reads;
    logic [3:0] pref;
    logic [3:0] writes;
  } eamt_cost_t;

  typedef struct packed {
    eamt_mode_t src;
    eamt_mode_t dst;
    logic is_long;
    logic [3:0] extra_clk;
  } eamt_req_t;

  localparam logic [7:0] EAMT_BUS_CLK = 8'h02;
  localparam logic [7:0] EAMT_LONG_ADD = 8'h02;
  localparam logic [3:0] EAMT_ONE = 4'h1;
  localparam logic [3:0] EAMT_TWO = 4'h2;
  localparam int EAMT_BUS_WIDTH = 16;
endpackage

// ===== hw/eamt_ea_cost.sv
`timescale 1ns/10ps
// Address-stage cost for one mode, registered
module eamt_ea_cost (
  input wire logic clk_sys, // Core clock
  input wire logic reset, // Sync reset
  input eamt_pkg::eamt_mode_t mode, // Addressing mode
  input wire logic calc_only, // Compute address, no read
  input wire logic is_long, // Long operand
  output eamt_pkg::eamt_cost_t cost // Cost, registered
);
  eamt_pkg::eamt_cost_t cost_r;
  eamt_pkg::eamt_cost_t cost_nxt;
  logic [3:0] nrd;
  logic [7:0] rdclk;
  logic [7:0] cut;

  // Fetch-variant base figures for word operands
  function automatic eamt_pkg::eamt_cost_t fetch_base(
    input eamt_pkg::eamt_mode_t m);
    eamt_pkg::eamt_cost_t c;
    c = '0;
    c.reads = eamt_pkg::EAMT_ONE;
    case (m)
      eamt_pkg::EAMT_M_DREG, eamt_pkg::EAMT_M_AREG: c.reads = '0;
      eamt_pkg::EAMT_M_IND, eamt_pkg::EAMT_M_POSTINC:
      begin
        c.head = 8'sh01; c.tail = 8'sh01; c.cycles = 8'h03;
      end
      eamt_pkg::EAMT_M_PREDEC:
      begin
        c.head = 8'sh02; c.tail = 8'sh02; c.cycles = 8'h04;
      end
      // Base register may be the program counter at no cost
      eamt_pkg::EAMT_M_D16, eamt_pkg::EAMT_M_ABSW:
      begin
        c.head = 8'sh01; c.tail = 8'sh03; c.cycles = 8'h05; c.pref = 4'h1;
      end
      eamt_pkg::EAMT_M_ABSL:
      begin
        c.head = 8'sh01; c.tail = 8'sh05; c.cycles = 8'h07; c.pref = 4'h2;
      end
      eamt_pkg::EAMT_M_IMMB, eamt_pkg::EAMT_M_IMMW:
      begin
        c.head = 8'sh01; c.tail = 8'sh01; c.cycles = 8'h03; c.pref = 4'h1;
        c.reads = '0;
      end
      eamt_pkg::EAMT_M_IMML:
      begin
        c.head = 8'sh01; c.tail = 8'sh03; c.cycles = 8'h05; c.pref = 4'h2;
        c.reads = '0;
      end
      // Index size and scale carry no input at all
      eamt_pkg::EAMT_M_D8X, eamt_pkg::EAMT_M_FX,
      eamt_pkg::EAMT_M_FINDX:
      begin
        c.head = 8'sh04; c.tail = 8'sh02; c.cycles = 8'h08; c.pref = 4'h1;
      end
      eamt_pkg::EAMT_M_FSUP:
      begin
        c.head = 8'sh02; c.tail = 8'sh02; c.cycles = 8'h06; c.pref = 4'h1;
      end
      eamt_pkg::EAMT_M_FD16, eamt_pkg::EAMT_M_FBD16:
      begin
        c.head = 8'sh01; c.tail = 8'sh03; c.cycles = 8'h07; c.pref = 4'h2;
      end
      eamt_pkg::EAMT_M_FD32, eamt_pkg::EAMT_M_FBD32:
      begin
        c.head = 8'sh01; c.tail = 8'sh05; c.cycles = 8'h09; c.pref = 4'h3;
      end
      eamt_pkg::EAMT_M_FIND:
      begin
        c.head = 8'sh01; c.tail = 8'sh01; c.cycles = 8'h05; c.pref = 4'h1;
      end
      eamt_pkg::EAMT_M_FBD16X, eamt_pkg::EAMT_M_FBD16XS:
      begin
        c.head = 8'sh02; c.tail = 8'sh02; c.cycles = 8'h08; c.pref = 4'h2;
      end
      eamt_pkg::EAMT_M_FBD32X, eamt_pkg::EAMT_M_FBD32XS:
      begin
        c.head = 8'sh01; c.tail = 8'sh03; c.cycles = 8'h09; c.pref = 4'h3;
      end
      default: c.reads = '0;
    endcase
    return c;
  endfunction

  always_comb
  begin
    cost_nxt = fetch_base(mode);
    // Long operand: two bus cycles and two more clocks
    nrd = (is_long && cost_nxt.reads != '0) ? eamt_pkg::EAMT_TWO
                                            : cost_nxt.reads;
    rdclk = 8'(nrd) * eamt_pkg::EAMT_BUS_CLK;
    if (nrd != cost_nxt.reads)
    begin
      cost_nxt.tail = cost_nxt.tail + 8'(eamt_pkg::EAMT_LONG_ADD);
      cost_nxt.cycles = cost_nxt.cycles + eamt_pkg::EAMT_LONG_ADD;
    end
    cost_nxt.reads = nrd;
    // Calculate variant: fetch minus the read time; a short tail holds
    // only part of the read, so only that part comes off
    cut = rdclk;
    if (cost_nxt.tail < $signed(rdclk))
      cut = 8'(cost_nxt.tail);
    if (calc_only && nrd != '0)
    begin
      cost_nxt.tail = cost_nxt.tail - $signed(cut);
      cost_nxt.cycles = cost_nxt.cycles - cut;
      cost_nxt.reads = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cost_r <= '0;
    else
      cost_r <= cost_nxt;
  end

  assign cost = cost_r;

  a_calc_no_read: assert property (@(posedge clk_sys) disable iff (reset)
    calc_only |=> cost.reads == '0)
    else $error("calc cost shows a read");
  a_calc_tail_pos: assert property (@(posedge clk_sys) disable iff (reset)
    calc_only |=> cost.tail >= 8'sh00)
    else $error("calc cost tail negative");
  a_long_two_rd: assert property (@(posedge clk_sys) disable iff (reset)
    (is_long && !calc_only && fetch_base(mode).reads != '0) |=>
      cost.reads == eamt_pkg::EAMT_TWO)
    else $error("long operand not two reads");
endmodule // eamt_ea_cost

// ===== hw/eamt_slow_adj.sv
`timescale 1ns/10ps
// Slow-bus prefetch adjustment, registered
module eamt_slow_adj (
  input wire logic clk_sys, // Core clock
  input wire logic reset, // Sync reset
  input eamt_pkg::eamt_cost_t cin, // Cost at two-clock bus
  input wire logic [3:0] extra, // Extra clocks for prefetches
  output eamt_pkg::eamt_cost_t cout // Adjusted cost
);
  eamt_pkg::eamt_cost_t c_r;
  eamt_pkg::eamt_cost_t c_nxt;
  logic signed [7:0] spill;

  always_comb
  begin
    c_nxt = cin;
    spill = 8'sh00;
    // Head soaks extra clocks first, rest lands on tail and total
    // No prefetch in this stage, so a slow bus costs it nothing
    if (cin.pref == '0)
      c_nxt = cin;
    else if (cin.head >= $signed({4'h0, extra}))
      c_nxt.head = cin.head - $signed({4'h0, extra});
    else
    begin
      spill = $signed({4'h0, extra}) - (cin.head > 0 ? cin.head : 8'sh00);
      c_nxt.head = (cin.head > 0) ? 8'sh00 : cin.head;
      c_nxt.tail = cin.tail + spill;
      c_nxt.cycles = cin.cycles + 8'(spill);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      c_r <= '0;
    else
      c_r <= c_nxt;
  end

  assign cout = c_r;

  a_head_absorb: assert property (@(posedge clk_sys) disable iff (reset)
    (cin.head >= $signed({4'h0, extra})) |=>
      (cout.cycles == $past(cin.cycles)))
    else $error("absorbed clocks changed total");
  a_no_pref_pass: assert property (@(posedge clk_sys) disable iff (reset)
    (cin.pref == '0) |=> (cout == $past(cin)))
    else $error("stage without prefetch was adjusted");
endmodule // eamt_slow_adj

// ===== hw/eamt_move_timing.sv
`timescale 1ns/10ps
// How it works
// - Computed address costs fetched cost minus read time, at most the tail, in tail and total.
// - All figures assume two-clock bus reads and writes.
// - Figures hold for the 16-bit external data path.
// - Read, prefetch and write counts lie inside the total.
// - Replacement fetches overlap the next operation by the tail.
// - Index size and scale never change timing.
// - Program counter as base costs the same as an address register.
// - Slow prefetch clocks come off head first, then onto tail and total.
// - Long operands take two bus cycles and add two clocks.
// - First matching move form in priority order wins.
// - Unlisted moves use the computed-source, fetched-destination form.
// - General form: source computed, destination fetched.
// - Immediate to computed address adds immediate fetch time.
module eamt_move_timing (
  input wire logic clk_sys, // Core clock, 20 MHz
  input wire logic reset, // Sync reset, active high
  input wire logic req_valid, // Lookup request
  input eamt_pkg::eamt_req_t req, // Source, destination, size
  output logic res_valid, // Result ready pulse
  output eamt_pkg::eamt_form_t res_form, // Selected move form
  output eamt_pkg::eamt_cost_t res_src, // Source address stage cost
  output eamt_pkg::eamt_cost_t res_op, // Move operation cost
  output eamt_pkg::eamt_cost_t res_total, // Combined instruction cost
  output logic signed [7:0] res_overlap // Overlap into next operation
);
  localparam logic [1:0] LAT = 2'h2;
  // Figures are for the 16-bit path and two-clock bus cycles
  localparam int PATH_OK = (eamt_pkg::EAMT_BUS_WIDTH == 16) ? 1 : 0;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} eamt_st_t;

  eamt_st_t st_r, st_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  eamt_pkg::eamt_req_t req_r, req_nxt;
  eamt_pkg::eamt_form_t form_r, form_nxt;
  eamt_pkg::eamt_form_t form_c;
  logic src_calc;
  eamt_pkg::eamt_mode_t src_mode;
  eamt_pkg::eamt_mode_t dst_mode;
  eamt_pkg::eamt_cost_t src_raw, src_adj, imm_raw, imm_adj;
  eamt_pkg::eamt_cost_t op_c, tot_c;
  logic res_valid_r, res_valid_nxt;
  eamt_pkg::eamt_cost_t op_r, op_nxt, tot_r, tot_nxt, srcq_r, srcq_nxt;
  logic signed [7:0] ovl_r, ovl_nxt;

  function automatic logic is_reg(input eamt_pkg::eamt_mode_t m);
    return m == eamt_pkg::EAMT_M_DREG || m == eamt_pkg::EAMT_M_AREG;
  endfunction

  function automatic logic is_imm(input eamt_pkg::eamt_mode_t m);
    return m == eamt_pkg::EAMT_M_IMMB || m == eamt_pkg::EAMT_M_IMMW ||
           m == eamt_pkg::EAMT_M_IMML;
  endfunction

  // Priority scan, top entry first
  function automatic eamt_pkg::eamt_form_t pick(
    input eamt_pkg::eamt_mode_t s, input eamt_pkg::eamt_mode_t d);
    if (is_reg(s) && is_reg(d)) return eamt_pkg::EAMT_F_RR;
    if (is_reg(d)) return eamt_pkg::EAMT_F_FEA_R;
    if (is_reg(s) && d == eamt_pkg::EAMT_M_IND) return eamt_pkg::EAMT_F_R_IND;
    if (is_reg(s) && d == eamt_pkg::EAMT_M_POSTINC)
      return eamt_pkg::EAMT_F_R_PI;
    if (is_reg(s) && d == eamt_pkg::EAMT_M_PREDEC)
      return eamt_pkg::EAMT_F_R_PD;
    if (is_reg(s)) return eamt_pkg::EAMT_F_R_CEA;
    if (d == eamt_pkg::EAMT_M_IND) return eamt_pkg::EAMT_F_FEA_IND;
    if (d == eamt_pkg::EAMT_M_POSTINC) return eamt_pkg::EAMT_F_FEA_PI;
    if (d == eamt_pkg::EAMT_M_PREDEC) return eamt_pkg::EAMT_F_FEA_PD;
    if (is_imm(s)) return eamt_pkg::EAMT_F_IMM_CEA;
    return eamt_pkg::EAMT_F_GEN;
  endfunction

  // Operation figures, word size; X write count set below
  function automatic eamt_pkg::eamt_cost_t op_base(
    input eamt_pkg::eamt_form_t f);
    eamt_pkg::eamt_cost_t c;
    c = '0;
    c.pref = eamt_pkg::EAMT_ONE;
    c.writes = eamt_pkg::EAMT_ONE;
    case (f)
      eamt_pkg::EAMT_F_RR, eamt_pkg::EAMT_F_FEA_R:
      begin
        c.cycles = 8'h02; c.writes = '0;
      end
      eamt_pkg::EAMT_F_R_IND:
      begin
        c.tail = 8'sh02; c.cycles = 8'h04;
      end
      eamt_pkg::EAMT_F_R_PI:
      begin
        c.head = 8'sh01; c.tail = 8'sh01; c.cycles = 8'h05;
      end
      eamt_pkg::EAMT_F_R_PD:
      begin
        c.head = 8'sh02; c.tail = 8'sh02; c.cycles = 8'h06;
      end
      eamt_pkg::EAMT_F_R_CEA:
      begin
        c.head = 8'sh01; c.tail = 8'sh03; c.cycles = 8'h05;
      end
      default:
      begin
        c.head = 8'sh02; c.tail = 8'sh02; c.cycles = 8'h06;
      end
    endcase
    return c;
  endfunction

  assign form_c = pick(req.src, req.dst);
  // General form: source is a computed address, no read
  assign src_calc = (form_r == eamt_pkg::EAMT_F_GEN);
  assign src_mode = (form_r == eamt_pkg::EAMT_F_RR ||
                     form_r == eamt_pkg::EAMT_F_R_IND ||
                     form_r == eamt_pkg::EAMT_F_R_PI ||
                     form_r == eamt_pkg::EAMT_F_R_PD ||
                     form_r == eamt_pkg::EAMT_F_R_CEA) ?
                    eamt_pkg::EAMT_M_DREG : req_r.src;

  // Only the immediate and general forms spend time on the destination
  always_comb
  begin
    if (form_r == eamt_pkg::EAMT_F_GEN ||
        form_r == eamt_pkg::EAMT_F_IMM_CEA)
      dst_mode = req_r.dst;
    else
      dst_mode = eamt_pkg::EAMT_M_DREG;
  end

  // Source side: fetched for most forms, computed for the general one
  eamt_ea_cost u_src (
    .clk_sys(clk_sys),
    .reset(reset),
    .mode(src_mode),
    .calc_only(src_calc),
    .is_long(req_r.is_long),
    .cost(src_raw)
  );

  // Destination cost: computed for the immediate form, fetched for the general one
  eamt_ea_cost u_dst (
    .clk_sys(clk_sys),
    .reset(reset),
    .mode(dst_mode),
    .calc_only(form_r == eamt_pkg::EAMT_F_IMM_CEA),
    .is_long(req_r.is_long),
    .cost(imm_raw)
  );

  eamt_slow_adj u_adj_s (
    .clk_sys(clk_sys),
    .reset(reset),
    .cin(src_raw),
    .extra(req_r.extra_clk),
    .cout(src_adj)
  );

  eamt_slow_adj u_adj_d (
    .clk_sys(clk_sys),
    .reset(reset),
    .cin(imm_raw),
    .extra(req_r.extra_clk),
    .cout(imm_adj)
  );

  always_comb
  begin
    op_c = op_base(form_r);
    if (req_r.is_long && op_c.writes != '0)
    begin
      op_c.writes = eamt_pkg::EAMT_TWO;
      op_c.tail = op_c.tail + 8'(eamt_pkg::EAMT_LONG_ADD);
      op_c.cycles = op_c.cycles + eamt_pkg::EAMT_LONG_ADD;
    end
    // Totals add stage totals; counts are already inside them
    tot_c.head = src_adj.head;
    tot_c.tail = op_c.tail;
    tot_c.cycles = src_adj.cycles + imm_adj.cycles + op_c.cycles;
    tot_c.reads = src_adj.reads + imm_adj.reads + op_c.reads;
    tot_c.pref = src_adj.pref + imm_adj.pref + op_c.pref;
    tot_c.writes = op_c.writes;
  end

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    req_nxt = req_r;
    form_nxt = form_r;
    res_valid_nxt = 1'b0;
    op_nxt = op_r;
    tot_nxt = tot_r;
    srcq_nxt = srcq_r;
    ovl_nxt = ovl_r;
    case (st_r)
      ST_IDLE:
        if (req_valid)
        begin
          req_nxt = req;
          form_nxt = form_c;
          cnt_nxt = '0;
          st_nxt = ST_WAIT;
        end
      ST_WAIT:
      begin
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == LAT)
        begin
          op_nxt = op_c;
          tot_nxt = tot_c;
          srcq_nxt = src_adj;
          // Fetches of the address stage run into the next head
          ovl_nxt = src_adj.tail;
          res_valid_nxt = (PATH_OK != 0);
          st_nxt = ST_DONE;
        end
      end
      ST_DONE: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      req_r <= '0;
      form_r <= eamt_pkg::EAMT_F_RR;
      res_valid_r <= 1'b0;
      op_r <= '0;
      tot_r <= '0;
      srcq_r <= '0;
      ovl_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      req_r <= req_nxt;
      form_r <= form_nxt;
      res_valid_r <= res_valid_nxt;
      op_r <= op_nxt;
      tot_r <= tot_nxt;
      srcq_r <= srcq_nxt;
      ovl_r <= ovl_nxt;
    end
  end

  assign res_valid = res_valid_r;
  assign res_form = form_r;
  assign res_src = srcq_r;
  assign res_op = op_r;
  assign res_total = tot_r;
  assign res_overlap = ovl_r;

  a_counts_inside: assert property (@(posedge clk_sys) disable iff (reset)
    res_valid |-> (res_total.cycles >= 8'((res_total.reads +
      res_total.pref) * 2)))
    else $error("bus counts exceed total");
  a_overlap_tail: assert property (@(posedge clk_sys) disable iff (reset)
    res_valid |-> res_overlap == res_src.tail)
    else $error("overlap differs from tail");
  a_gen_no_src_rd: assert property (@(posedge clk_sys) disable iff (reset)
    (res_valid && res_form == eamt_pkg::EAMT_F_GEN) |->
      res_src.reads == '0)
    else $error("general form source read");
  a_req_to_res: assert property (@(posedge clk_sys) disable iff (reset)
    (req_valid && st_r == ST_IDLE) |-> ##4 res_valid)
    else $error("result not in four cycles");
  a_rr_form: assert property (@(posedge clk_sys) disable iff (reset)
    (req_valid && st_r == ST_IDLE && is_reg(req.src) && is_reg(req.dst))
      |=> form_r == eamt_pkg::EAMT_F_RR)
    else $error("register move not first form");
  a_move_long_w: assert property (@(posedge clk_sys) disable iff (reset)
    (res_valid && req_r.is_long && res_op.writes != '0) |->
      res_op.writes == eamt_pkg::EAMT_TWO)
    else $error("long move writes not two");
  a_total_head: assert property (@(posedge clk_sys) disable iff (reset)
    res_valid |-> res_total.head == res_src.head)
    else $error("total head differs from source head");
  a_total_tail: assert property (@(posedge clk_sys) disable iff (reset)
    res_valid |-> res_total.tail == res_op.tail)
    else $error("total tail differs from move tail");
  // A busy block must not pick up a second request
  a_busy_ignore: assert property (@(posedge clk_sys) disable iff (reset)
    (req_valid && st_r != ST_IDLE) |=> $stable(req_r))
    else $error("request taken while busy");
  a_rr_no_ea: assert property (@(posedge clk_sys) disable iff (reset)
    (res_valid && res_form == eamt_pkg::EAMT_F_RR) |->
      res_total.cycles == res_op.cycles)
    else $error("register move charged address time");
endmodule // eamt_move_timing

// ===== tb/eamt_testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("wrong value t=%0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end

module testbench;
  typedef struct {
    eamt_pkg::eamt_form_t form;
    eamt_pkg::eamt_cost_t src;
    eamt_pkg::eamt_cost_t op;
    eamt_pkg::eamt_cost_t tot;
    int t;
  } eamt_note_t;

  // Entries are {head, tail, cycles, prefetches}, word size, two-clock bus
  localparam logic [15:0] fetch_tab [0:23] = '{
    16'h0000, 16'h0000, 16'h1130, 16'h1130, 16'h2240, 16'h1351,
    16'h1351, 16'h1572, 16'h1131, 16'h1131, 16'h1352, 16'h4281,
    16'h2261, 16'h1372, 16'h1593, 16'h1151, 16'h4281, 16'h4281,
    16'h1372, 16'h1593, 16'h2282, 16'h1393, 16'h2282, 16'h1393};
  // Immediates have no computed form; their slots are never used
  localparam logic [15:0] calc_tab [0:23] = '{
    16'h0000, 16'h0000, 16'h1020, 16'h1020, 16'h2020, 16'h1131,
    16'h1131, 16'h1352, 16'h0000, 16'h0000, 16'h0000, 16'h4061,
    16'h2041, 16'h1152, 16'h1373, 16'h1041, 16'h4061, 16'h4061,
    16'h1152, 16'h1373, 16'h2062, 16'h1173, 16'h2062, 16'h1173};
  localparam logic [15:0] op_tab [0:10] = '{
    16'h0021, 16'h0021, 16'h0241, 16'h1151, 16'h2261, 16'h1351,
    16'h2261, 16'h2261, 16'h2261, 16'h2261, 16'h2261};

  logic clk_sys = 1'b0;
  logic reset;
  logic req_valid;
  eamt_pkg::eamt_req_t req;
  logic res_valid;
  eamt_pkg::eamt_form_t res_form;
  eamt_pkg::eamt_cost_t res_src;
  eamt_pkg::eamt_cost_t res_op;
  eamt_pkg::eamt_cost_t res_total;
  logic signed [7:0] res_overlap;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int dl [0:5] = '{0, 2, 3, 4, 6, 13};
  eamt_note_t q [$];

  eamt_move_timing uut (
    .clk_sys(clk_sys),
    .reset(reset),
    .req_valid(req_valid),
    .req(req),
    .res_valid(res_valid),
    .res_form(res_form),
    .res_src(res_src),
    .res_op(res_op),
    .res_total(res_total),
    .res_overlap(res_overlap)
  );

  always #25 clk_sys = ~clk_sys;

  function automatic eamt_pkg::eamt_cost_t mk(logic [15:0] v, logic [3:0] rd);
    eamt_pkg::eamt_cost_t c;
    c = '0;
    c.head = {4'h0, v[15:12]};
    c.tail = {4'h0, v[11:8]};
    c.cycles = {4'h0, v[7:4]};
    c.pref = v[3:0];
    c.reads = rd;
    return c;
  endfunction

  // Extra prefetch clocks eat the head before they reach tail and total
  function automatic eamt_pkg::eamt_cost_t slow(eamt_pkg::eamt_cost_t c,
                                                logic [3:0] ex);
    logic [7:0] e8;
    e8 = {4'h0, ex};
    if (c.pref == 4'h0)
      return c;
    if (e8 <= c.head)
      c.head = c.head - e8;
    else
    begin
      c.tail = c.tail + (e8 - c.head);
      c.cycles = c.cycles + (e8 - c.head);
      c.head = 8'h00;
    end
    return c;
  endfunction

  // Fetched-address cost of one mode, long operands included
  function automatic eamt_pkg::eamt_cost_t fcost(int m, logic lg);
    eamt_pkg::eamt_cost_t c;
    logic rd;
    rd = m >= 2 && !(m >= 8 && m <= 10);
    c = mk(fetch_tab[m], rd ? (lg ? 4'h2 : 4'h1) : 4'h0);
    if (rd && lg)
    begin
      c.tail = c.tail + 8'sh02;
      c.cycles = c.cycles + 8'h02;
    end
    return c;
  endfunction

  function automatic eamt_pkg::eamt_form_t exp_form(int s, int d);
    if (s < 2 && d < 2)
      return eamt_pkg::EAMT_F_RR;
    if (d < 2)
      return eamt_pkg::EAMT_F_FEA_R;
    if (s < 2 && d <= 4)
      return eamt_pkg::eamt_form_t'(d);
    if (s < 2)
      return eamt_pkg::EAMT_F_R_CEA;
    if (d <= 4)
      return eamt_pkg::eamt_form_t'(d + 4);
    if (s >= 8 && s <= 10)
      return eamt_pkg::EAMT_F_IMM_CEA;
    return eamt_pkg::EAMT_F_GEN;
  endfunction

  function automatic logic bus_ok(eamt_pkg::eamt_cost_t c);
    return c.cycles >= ({4'h0, c.reads} + {4'h0, c.pref}
                        + {4'h0, c.writes}) * 8'h02;
  endfunction

  task automatic send(int s, int d, logic lg, logic [3:0] ex, logic note,
                      int gap);
    eamt_note_t n;
    n.form = exp_form(s, d);
    n.op = mk(op_tab[n.form], 4'h0);
    if (n.form > eamt_pkg::EAMT_F_FEA_R)
    begin
      n.op.writes = lg ? 4'h2 : 4'h1;
      n.op.tail = n.op.tail + (lg ? 8'sh02 : 8'sh00);
      n.op.cycles = n.op.cycles + (lg ? 8'h02 : 8'h00);
    end
    if (n.form == eamt_pkg::EAMT_F_GEN)
      n.src = mk(calc_tab[s], 4'h0);
    else
      n.src = fcost(s, lg);
    n.src = slow(n.src, ex);
    n.tot = mk(calc_tab[d], 4'h0);
    if (n.form == eamt_pkg::EAMT_F_GEN)
      n.tot = slow(fcost(d, lg), ex);
    else if (n.form != eamt_pkg::EAMT_F_IMM_CEA)
      n.tot = '0;
    n.tot.cycles = n.tot.cycles + n.src.cycles + n.op.cycles;
    n.tot.reads = n.tot.reads + n.src.reads + n.op.reads;
    n.tot.pref = n.tot.pref + n.src.pref + n.op.pref;
    @(posedge clk_sys);
    n.t = cyc;
    req_valid <= 1'b1;
    req <= '{src: eamt_pkg::eamt_mode_t'(s), dst: eamt_pkg::eamt_mode_t'(d),
             is_long: lg, extra_clk: ex};
    if (note)
      q.push_back(n);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (gap) @(posedge clk_sys);
  endtask

  task automatic check_result;
    eamt_note_t e;
    if (q.size() == 0)
      `CHK(1'b0, 1'b1)
    else
    begin
      e = q.pop_front();
      `CHK(cyc - e.t, 5)
      `CHK(res_form, e.form)
      `CHK(res_op, e.op)
      `CHK(res_total.tail, e.op.tail)
      `CHK(res_total.writes, e.op.writes)
      `CHK(bus_ok(res_total), 1'b1)
      `CHK(bus_ok(res_src), 1'b1)
      `CHK(res_src, e.src)
      `CHK(res_overlap, e.src.tail)
      `CHK(res_total.head, e.src.head)
      `CHK(res_total.cycles, e.tot.cycles)
      `CHK(res_total.reads, e.tot.reads)
      `CHK(res_total.pref, e.tot.pref)
    end
  endtask

  task end_sim;
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      end_sim;
    end
    if (res_valid === 1'b1)
      check_result;
  end

  initial
  begin
    int s;
    int d;
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    void'($urandom(77));
    repeat (6) @(posedge clk_sys);
    `CHK(res_valid, 1'b0)
    `CHK(res_form, eamt_pkg::EAMT_F_RR)
    `CHK(res_total, eamt_pkg::eamt_cost_t'(0))
    reset <= 1'b0;
    for (int i = 0; i < 24; i++)
      for (int j = 0; j < 6; j++)
        send(i, dl[j], i[0], (i >= 11) ? 4'(i % 7) : 4'h0, 1'b1, 4);
    // Second request lands while busy and must leave no trace
    send(13, 0, 1'b0, 4'h3, 1'b1, 0);
    send(5, 2, 1'b1, 4'h0, 1'b0, 4);
    repeat (200)
    begin
      s = $urandom_range(0, 23);
      d = $urandom_range(0, 20);
      if (d >= 8)
        d = d + 3;
      send(s, d, 1'($urandom_range(0, 1)),
           (s >= 11) ? 4'($urandom_range(0, 6)) : 4'h0, 1'b1, 4);
    end
    repeat (8) @(posedge clk_sys);
    `CHK(q.size(), 0)
    end_sim;
  end
endmodule // testbench
